// ===== clk_fsm_ctrl_regs.vh
`ifndef CLK_FSM_CTRL_REGS_VH
`define CLK_FSM_CTRL_REGS_VH
// Clock source select codes
`define SRC_FAST_INT    2'h0
`define SRC_PLL         2'h1
`define SRC_SLOW_INT    2'h2
`define SRC_FAST_EXT    2'h3
// Validate mask bit positions
`define VAL_SLOT0       0
`define VAL_SLOT1       1
`define VAL_SLOT2       2
`define VAL_SLOT3       3
`define VAL_DITHER      4
// Counts and widths
`define NUM_FSM         6
`define TIME_W          16
`define DITHER_W        8
`define CONV_DIV_RST    8'h00
`define WAKE_DIV_MAX    4'h8
`define FSM_PRE_RST     3'h0
`define TIME_RST        16'h0000
`endif

// ===== clk_div_gen.v
`timescale 1ns/1ps
`include "clk_fsm_ctrl_regs.vh"
module clk_div_gen (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       nrst_i,
  // Source ticks and selection
  input  wire [3:0] src_tick_i,
  input  wire [1:0] src_sel_i,
  input  wire [7:0] div_i,
  // Output tick
  output reg        tick_o
);
  reg  [7:0] cnt;
  wire       src_tick;

  assign src_tick = src_tick_i[src_sel_i];

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt    <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (src_tick) begin
        if (cnt >= div_i) begin
          cnt    <= 8'h00;
          tick_o <= 1'b1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end
endmodule // clk_div_gen

// ===== periph_clock_and_fsm_timing_ctrl.v
// Contract
// - Converter clock source from four oscillators
// - Converter clock is source over n+1
// - Wakeup clock divides converter by 2^k, k clamped to 8
// - Each machine selects its own source
// - Each machine prescaler divides by 2^k
// - Start command runs one machine only
// - Stop command halts one machine only
// - Four 16-bit time slots per machine
// - Pending validation refuses writes and validates
// - Validation copies times into shadows
// - One validation takes any slot mask
// - One software trigger flag per machine
// - Software trigger acts like hardware event
`timescale 1ns/1ps
`include "clk_fsm_ctrl_regs.vh"
module periph_clock_and_fsm_timing_ctrl (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        nrst_i,
  // Oscillator ticks: fast_int, pll, slow_int, fast_ext
  input  wire        fast_internal_osc_i,
  input  wire        pll_i,
  input  wire        slow_internal_osc_i,
  input  wire        fast_external_osc_i,
  // Converter and wakeup clock config
  input  wire [1:0]  conv_src_sel_i,
  input  wire [7:0]  conv_div_i,
  input  wire [3:0]  auto_wakeup_unit_div_i,
  // Machine clock config, 2 and 3 bits per machine
  input  wire [11:0] fsm_src_sel_i,
  input  wire [17:0] fsm_prescale_i,
  // Run control, one bit per machine
  input  wire [5:0]  fsm_start_i,
  input  wire [5:0]  fsm_stop_i,
  // Time slot write
  input  wire        time_wr_i,
  input  wire [2:0]  time_wr_fsm_i,
  input  wire [1:0]  time_wr_slot_i,
  input  wire [15:0] time_wr_data_i,
  input  wire        dither_wr_i,
  input  wire [7:0]  dither_wr_data_i,
  // Validation request
  input  wire        validate_i,
  input  wire [2:0]  validate_fsm_i,
  input  wire [4:0]  validate_mask_i,
  // Software event triggers
  input  wire [5:0]  software_event_trigger_i,
  // Hardware event inputs to the connection matrix
  input  wire [5:0]  hw_event_i,
  // Clock ticks
  output wire        conv_clk_tick_o,
  output reg         wake_clk_tick_o,
  output wire [5:0]  fsm_clk_tick_o,
  // Machine status
  output reg  [5:0]  fsm_running_o,
  output reg  [5:0]  validate_pending_o,
  output reg         time_wr_ok_o,
  output reg         validate_ok_o,
  // Shadow time values, machine m slot s at [(m*4+s)*16 +: 16]
  output reg  [383:0] shadow_time_o,
  output reg  [47:0]  shadow_dither_o,
  // Machine event inputs after software triggers merge
  output reg  [5:0]  fsm_event_o
);
  wire [3:0] osc_ticks;
  reg  [8:0] wake_cnt;
  wire [8:0] wake_mask;
  wire [5:0] src_tick;
  reg  [15:0] time_work [0:23];
  reg  [7:0]  dither_work [0:5];
  reg  [4:0]  pend_mask [0:5];
  reg  [5:0]  sw_flag;
  integer     i;
  integer     s;
  genvar      g;

  assign osc_ticks = {fast_external_osc_i, slow_internal_osc_i,
                      pll_i, fast_internal_osc_i};

  // Wakeup divide mask: 2^k - 1
  function [8:0] pow2_mask;
    input [3:0] k;
    begin
      pow2_mask = (9'h001 << k) - 9'h001;
    end
  endfunction

  // Settings above eight clamp to divide-by-256
  function [3:0] clamp_wake;
    input [3:0] k;
    begin
      clamp_wake = (k > `WAKE_DIV_MAX) ? `WAKE_DIV_MAX : k;
    end
  endfunction

  // Index names one of the six machines
  function fsm_ok;
    input [2:0] idx;
    begin
      fsm_ok = (idx < 3'h6);
    end
  endfunction

  assign wake_mask = pow2_mask(clamp_wake(auto_wakeup_unit_div_i));

  clk_div_gen u_conv_div (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .src_tick_i (osc_ticks),
    .src_sel_i  (conv_src_sel_i),
    .div_i      (conv_div_i),
    .tick_o     (conv_clk_tick_o)
  );

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_cnt        <= 9'h000;
      wake_clk_tick_o <= 1'b0;
    end else begin
      wake_clk_tick_o <= 1'b0;
      if (conv_clk_tick_o) begin
        if ((wake_cnt & wake_mask) == wake_mask) begin
          wake_cnt        <= 9'h000;
          wake_clk_tick_o <= 1'b1;
        end else begin
          wake_cnt <= wake_cnt + 9'h001;
        end
      end
    end
  end

  // Per-machine source select, then power-of-two prescaler
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_fsm
      reg  [6:0] cnt;
      reg        tick;
      wire [8:0] mask;
      assign src_tick[g] = osc_ticks[fsm_src_sel_i[g*2 +: 2]];
      assign mask = pow2_mask({1'b0, fsm_prescale_i[g*3 +: 3]});
      assign fsm_clk_tick_o[g] = tick;
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cnt  <= 7'h00;
          tick <= 1'b0;
        end else begin
          tick <= 1'b0;
          if (src_tick[g]) begin
            if ((cnt & mask[6:0]) == mask[6:0]) begin
              cnt  <= 7'h00;
              tick <= 1'b1;
            end else begin
              cnt <= cnt + 7'h01;
            end
          end
        end
      end
    end
  endgenerate

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fsm_running_o      <= 6'h00;
      validate_pending_o <= 6'h00;
      time_wr_ok_o       <= 1'b0;
      validate_ok_o      <= 1'b0;
      shadow_time_o      <= 384'h0;
      shadow_dither_o    <= 48'h0;
      sw_flag            <= 6'h00;
      fsm_event_o        <= 6'h00;
      for (i = 0; i < 24; i = i + 1)
        time_work[i] <= `TIME_RST;
      for (i = 0; i < 6; i = i + 1) begin
        dither_work[i] <= 8'h00;
        pend_mask[i]   <= 5'h00;
      end
    end else begin
      // Start wins over stop on the same machine
      fsm_running_o <= (fsm_running_o & ~fsm_stop_i) | fsm_start_i;
      time_wr_ok_o  <= 1'b0;
      validate_ok_o <= 1'b0;
      // Shadow transfer on the machine's next clock tick
      for (i = 0; i < 6; i = i + 1) begin
        if (validate_pending_o[i] && fsm_clk_tick_o[i]) begin
          for (s = 0; s < 4; s = s + 1)
            if (pend_mask[i][s])
              shadow_time_o[(i*4+s)*16 +: 16] <= time_work[i*4+s];
          if (pend_mask[i][`VAL_DITHER])
            shadow_dither_o[i*8 +: 8] <= dither_work[i];
          validate_pending_o[i] <= 1'b0;
          pend_mask[i]          <= 5'h00;
        end
      end
      if (time_wr_i && fsm_ok(time_wr_fsm_i)) begin
        if (!validate_pending_o[time_wr_fsm_i]) begin
          time_work[time_wr_fsm_i*4 + time_wr_slot_i] <= time_wr_data_i;
          time_wr_ok_o <= 1'b1;
        end
      end
      if (dither_wr_i && fsm_ok(time_wr_fsm_i)) begin
        if (!validate_pending_o[time_wr_fsm_i]) begin
          dither_work[time_wr_fsm_i] <= dither_wr_data_i;
          time_wr_ok_o <= 1'b1;
        end
      end
      // Request during a completing transfer is refused, pending still set
      if (validate_i && fsm_ok(validate_fsm_i) &&
          !validate_pending_o[validate_fsm_i]) begin
        pend_mask[validate_fsm_i]          <= validate_mask_i;
        validate_pending_o[validate_fsm_i] <= 1'b1;
        validate_ok_o                      <= 1'b1;
      end
      // Trigger flag holds until the machine's clock sees it
      sw_flag     <= (sw_flag & ~fsm_clk_tick_o) | software_event_trigger_i;
      fsm_event_o <= hw_event_i | sw_flag | software_event_trigger_i;
    end
  end
endmodule // periph_clock_and_fsm_timing_ctrl

// ===== periph_clock_and_fsm_timing_ctrl_chk.sv
`timescale 1ns/1ps
module periph_clock_and_fsm_timing_ctrl_chk (
  // Clock, reset, requests, machine ticks and run state
  input wire         core_clk_i, nrst_i, time_wr_i, validate_i,
  input wire [2:0]   time_wr_fsm_i, validate_fsm_i,
  input wire [5:0]   fsm_start_i, fsm_stop_i, software_event_trigger_i,
  input wire [5:0]   hw_event_i, fsm_clk_tick_o, fsm_running_o,
  // Results
  input wire         time_wr_ok_o, validate_ok_o,
  input wire [5:0]   validate_pending_o, fsm_event_o,
  input wire [383:0] shadow_time_o
);
  wire [5:0] cmd = fsm_start_i | fsm_stop_i;
  wire [5:0] stp = fsm_stop_i & ~fsm_start_i;
  wire [5:0] evt = software_event_trigger_i | hw_event_i;
  wire [5:0] done = validate_pending_o & fsm_clk_tick_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_WR_ACC: assert property (time_wr_i && time_wr_fsm_i < 3'h6 &&
    !validate_pending_o[time_wr_fsm_i] |=> time_wr_ok_o) else $error("wr ack");
  AST_WR_REF: assert property (time_wr_i && (time_wr_fsm_i > 3'h5 ||
    validate_pending_o[time_wr_fsm_i]) |=> !time_wr_ok_o) else $error("wr ref");
  AST_VAL_ACC: assert property (validate_i && validate_fsm_i < 3'h6 &&
    !validate_pending_o[validate_fsm_i] |=> validate_ok_o &&
    validate_pending_o[$past(validate_fsm_i)]) else $error("val ack");
  AST_VAL_REF: assert property (validate_i &&
    validate_pending_o[validate_fsm_i] |=> !validate_ok_o) else $error("vref");
  AST_START: assert property (|fsm_start_i |=>
    (fsm_running_o & $past(fsm_start_i)) == $past(fsm_start_i))
    else $error("start");
  AST_STOP: assert property (|stp |=>
    (fsm_running_o & $past(stp)) == 6'h0) else $error("stop");
  AST_RUN_ISO: assert property (((fsm_running_o ^ $past(fsm_running_o))
    & ~$past(cmd)) == 6'h0) else $error("run isolation");
  AST_SHADOW: assert property (!$stable(shadow_time_o) |->
    |$past(done)) else $error("shadow moved");
  AST_PEND_CLR: assert property (($past(validate_pending_o)
    & ~validate_pending_o & ~$past(done)) == 6'h0) else $error("pending");
  AST_EVT: assert property (|evt |=>
    (fsm_event_o & $past(evt)) == $past(evt)) else $error("event");
  cover property (validate_ok_o);
  cover property (|done);
  cover property (|stp);
endmodule // periph_clock_and_fsm_timing_ctrl_chk
bind periph_clock_and_fsm_timing_ctrl periph_clock_and_fsm_timing_ctrl_chk
  i_periph_clock_and_fsm_timing_ctrl_chk (.*);

// ===== tb_periph_clock_and_fsm_timing_ctrl.sv
`timescale 1ns/1ps
`define CHK(s,e,a) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", s, e, a); end end
module tb_periph_clock_and_fsm_timing_ctrl;
  logic core_clk_i, nrst_i, fast_internal_osc_i, pll_i, slow_internal_osc_i;
  logic fast_external_osc_i, time_wr_i, dither_wr_i, validate_i;
  logic conv_clk_tick_o, wake_clk_tick_o, time_wr_ok_o, validate_ok_o;
  logic [1:0] conv_src_sel_i, time_wr_slot_i;
  logic [2:0] time_wr_fsm_i, validate_fsm_i;
  logic [3:0] auto_wakeup_unit_div_i;
  logic [4:0] validate_mask_i;
  logic [5:0] fsm_start_i, fsm_stop_i, software_event_trigger_i, hw_event_i;
  logic [5:0] fsm_clk_tick_o, fsm_running_o, validate_pending_o, fsm_event_o;
  logic [7:0] conv_div_i, dither_wr_data_i;
  logic [11:0] fsm_src_sel_i;
  logic [15:0] time_wr_data_i;
  logic [17:0] fsm_prescale_i;
  logic [383:0] shadow_time_o;
  logic [47:0] shadow_dither_o;
  int failures, compares, n[8];
  periph_clock_and_fsm_timing_ctrl i_periph_clock_and_fsm_timing_ctrl (.*);
  initial begin
    core_clk_i = 0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task cyc(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task osc(input [3:0] v);
    {fast_external_osc_i, slow_internal_osc_i, pll_i, fast_internal_osc_i} = v;
  endtask
  task count(input int w);
    n = '{default:0};
    repeat (w) begin
      cyc(1);
      n[0] += conv_clk_tick_o;
      n[1] += wake_clk_tick_o;
      for (int m = 0; m < 6; m++) n[m+2] += fsm_clk_tick_o[m];
    end
  endtask
  task t_div;
    for (int s = 0; s < 4; s++) begin
      conv_src_sel_i = s;
      conv_div_i = 8'h02;
      auto_wakeup_unit_div_i = 2 * s;
      osc(4'h1 << s);
      cyc(200);
      count(192);
      `CHK("conv", 64, n[0])
      `CHK("wake", 64 >> (2 * s), n[1])
    end
  endtask
  task t_fsm;
    for (int p = 0; p < 2; p++) begin
      osc(p ? 4'ha : 4'h5);
      cyc(40);
      count(64);
      for (int m = 0; m < 6; m++)
        `CHK("fsm tick", (m % 2 == p) ? 64 >> m : 0, n[m+2])
    end
  endtask
  task t_run;
    fsm_start_i = 6'h14;
    cyc(1);
    fsm_start_i = 6'h01;
    fsm_stop_i = 6'h04;
    cyc(1);
    {fsm_start_i, fsm_stop_i} = '0;
    cyc(1);
    `CHK("run", 6'h11, fsm_running_o)
  endtask
  task wr(input [1:0] s, input [15:0] v, input ok);
    {time_wr_i, time_wr_fsm_i, time_wr_slot_i, time_wr_data_i} = {4'hb, s, v};
    cyc(1);
    time_wr_i = 0;
    `CHK("wr ok", ok, time_wr_ok_o)
    cyc(1);
  endtask
  task val(input [4:0] mk, input ok);
    {validate_i, validate_fsm_i, validate_mask_i} = {4'hb, mk};
    cyc(1);
    validate_i = 0;
    `CHK("val ok", ok, validate_ok_o)
    `CHK("pending", 1'b1, validate_pending_o[3])
    cyc(1);
  endtask
  task drain(input [63:0] e);
    osc(4'hf);
    for (int i = 0; i < 40 && validate_pending_o[3] !== 1'b0; i++) cyc(1);
    `CHK("pending", 1'b0, validate_pending_o[3])
    `CHK("shadow", e, shadow_time_o[192 +: 64])
    osc(4'h0);
  endtask
  task t_time;
    osc(4'h0);
    for (int s = 0; s < 4; s++) wr(s, 16'h1000 + s, 1);
    {dither_wr_i, dither_wr_data_i} = 9'h1a5;
    cyc(1);
    dither_wr_i = 0;
    `CHK("unvalidated", 64'h0, shadow_time_o[192 +: 64])
    val(5'h05, 1);
    wr(2'h1, 16'hbeef, 0);
    val(5'h1a, 0);
    drain(64'h0000_1002_0000_1000);
    val(5'h1a, 1);
    drain(64'h1003_1002_1001_1000);
    `CHK("dither", 8'ha5, shadow_dither_o[24 +: 8])
  endtask
  task t_evt;
    hw_event_i = 6'h02;
    software_event_trigger_i = 6'h20;
    cyc(1);
    software_event_trigger_i = 0;
    cyc(1);
    `CHK("event", 6'h22, fsm_event_o & 6'h22)
  endtask
  task tally_and_finish;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    nrst_i = 0;
    {time_wr_i, dither_wr_i, validate_i, conv_src_sel_i, time_wr_slot_i,
     time_wr_fsm_i, validate_fsm_i, auto_wakeup_unit_div_i, validate_mask_i,
     fsm_start_i, fsm_stop_i, software_event_trigger_i, hw_event_i,
     conv_div_i, dither_wr_data_i, time_wr_data_i} = '0;
    osc(4'h0);
    fsm_src_sel_i = 12'h4e4;
    fsm_prescale_i = 18'h2c688;
    cyc(16);
    nrst_i = 1;
    cyc(1);
    t_div;
    t_fsm;
    t_run;
    t_time;
    t_evt;
    tally_and_finish;
  end
  initial begin
    #100us;
    failures++;
    tally_and_finish;
  end
endmodule // tb_periph_clock_and_fsm_timing_ctrl
